// ### bzt_pkg.sv
package bzt_pkg;
   // register addresses (printed offsets are byte addresses, word aligned)
   localparam logic [16:0] BZT_ZONE0_ADDR = 17'h0F904;
   localparam logic [16:0] BZT_ZONE1_ADDR = 17'h0F906;
   localparam logic [16:0] BZT_IO_ZONE_TIMING_CONFIG_ADDR = 17'h0F908;
   localparam logic [16:0] BZT_BUSCFG_ADDR = 17'h0F90A;
   localparam logic [16:0] BZT_MODCFG_ADDR = 17'h0F90C;
   localparam logic [16:0] BZT_STATUS_ADDR = 17'h0F90E;
   // reset values
   localparam logic [15:0] BZT_ZONE_RESET = 16'h069F;
   localparam logic [15:0] BZT_IO_ZONE_TIMING_CONFIG_RESET = 16'h069F;
   localparam logic [15:0] BZT_BUSCFG_RESET = 16'h0000;
   localparam logic [15:0] BZT_MODCFG_RESET = 16'h0000;
   // zone timing field layout
   localparam int BZT_WAIT_LSB = 0;
   localparam int BZT_HOLD_LSB = 4;
   localparam int BZT_BW_BIT = 7;
   localparam int BZT_POST_IDLE_ENABLE_BIT = 9;
   localparam int BZT_PRELIMINARY_IDLE_ENABLE_BIT = 10;
   localparam int BZT_FRE_BIT = 11;
   localparam logic [15:0] BZT_ZONE_WMASK = 16'h0EB7;
   // loose control bits
   localparam int BZT_EWR_BIT = 0;
   localparam int BZT_ZERO_WAIT_STATE_SELECT_BIT = 0;
   // address windows
   localparam logic [16:0] BZT_FLASH_LO_END = 17'h0BFFF;
   localparam logic [16:0] BZT_FLASH_HI_BEG = 17'h10000;
   localparam logic [16:0] BZT_FLASH_HI_END = 17'h1BFFF;
   localparam logic [16:0] BZT_RAM_BEG = 17'h0C000;
   localparam logic [16:0] BZT_RAM_END = 17'h0CFFF;
   localparam logic [16:0] BZT_EE_BEG = 17'h0F000;
   localparam logic [16:0] BZT_EE_END = 17'h0F27F;
   localparam logic [16:0] BZT_PER_BEG = 17'h0F800;
   localparam logic [16:0] BZT_PER_END = 17'h0FAFF;
   localparam logic [16:0] BZT_PORT_BEG = 17'h0FB00;
   localparam logic [16:0] BZT_PORT_END = 17'h0FB16;
   localparam logic [16:0] BZT_PER2_BEG = 17'h0FC00;
   localparam logic [16:0] BZT_BOOT_BEG = 17'h0E000;
   localparam logic [16:0] BZT_BOOT_END = 17'h0EFFF;
   // fixed cycle counts
   localparam logic [3:0] BZT_PORT_BASE_WAIT = 4'h2;
   localparam logic [3:0] BZT_PER_WAIT = 4'h1;

   typedef enum logic [2:0] {
      BZT_Z_NONE = 3'h0,
      BZT_Z_FLASH = 3'h1,
      BZT_Z_BOOT = 3'h2,
      BZT_Z_RAM = 3'h3,
      BZT_Z_EE = 3'h4,
      BZT_Z_PER = 3'h5,
      BZT_Z_PORT = 3'h6
   } bzt_zone_t;
endpackage

// ### bzt_decode.sv
`timescale 1ns/1ps
module bzt_decode
   import bzt_pkg::*;
(
   input wire logic [16:0] addr_i,
   output bzt_zone_t zone_o
);
   always_comb begin
      if (addr_i <= BZT_FLASH_LO_END ||
          (addr_i >= BZT_FLASH_HI_BEG && addr_i <= BZT_FLASH_HI_END)) begin
         zone_o = BZT_Z_FLASH;
      end else if (addr_i >= BZT_RAM_BEG && addr_i <= BZT_RAM_END) begin
         zone_o = BZT_Z_RAM;
      end else if (addr_i >= BZT_BOOT_BEG && addr_i <= BZT_BOOT_END) begin
         zone_o = BZT_Z_BOOT;
      end else if (addr_i >= BZT_EE_BEG && addr_i <= BZT_EE_END) begin
         zone_o = BZT_Z_EE;
      end else if (addr_i >= BZT_PORT_BEG && addr_i <= BZT_PORT_END) begin
         zone_o = BZT_Z_PORT;
      end else if ((addr_i >= BZT_PER_BEG && addr_i <= BZT_PER_END) ||
                   (addr_i >= BZT_PER2_BEG && addr_i < BZT_FLASH_HI_BEG)) begin
         zone_o = BZT_Z_PER;
      end else begin
         zone_o = BZT_Z_NONE;
      end
   end
endmodule

// ### bzt_timing.sv
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module bzt_timing
   import bzt_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   // register port
   input wire logic [16:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   // cpu bus cycle request
   input wire logic cyc_req_i,
   input wire logic cyc_write_i,
   input wire logic [16:0] cyc_addr_i,
   output logic cyc_ready_o,
   output logic cyc_busy_o,
   // memory side strobes
   output logic mem_strobe_o,
   output logic [2:0] mem_zone_o,
   output logic mem_wide_o
);
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_PRE = 6'b000010,
      ST_WAIT = 6'b000100,
      ST_HOLD = 6'b001000,
      ST_POST = 6'b010000,
      ST_DONE = 6'b100000
   } bzt_state_t;

   bzt_state_t state_q;
   logic [15:0] zone0_static_timing_config_q;
   logic [15:0] zone1_static_timing_config_q;
   logic [15:0] io_zone_timing_config_q;
   logic [15:0] general_bus_config_q;
   logic [15:0] module_config_q;
   logic [15:0] rdata_d;
   bzt_zone_t zone_new;
   bzt_zone_t prev_zone_q;
   bzt_zone_t cur_zone_q;
   logic prev_valid_q;
   logic post_pending_q;
   logic [3:0] wait_d;
   logic [3:0] wait_q;
   logic [1:0] hold_d;
   logic [1:0] hold_q;
   logic pre_d;
   logic post_d;
   logic post_q;
   logic wide_d;
   logic zone_change;
   logic fast_read;
   logic early_write;
   logic zero_ws;
   logic [15:0] cfg_sel;

   bzt_decode u_decode (
      .addr_i(cyc_addr_i),
      .zone_o(zone_new)
   );

   assign fast_read = zone0_static_timing_config_q[BZT_FRE_BIT];
   assign early_write = general_bus_config_q[BZT_EWR_BIT];
   assign zero_ws = module_config_q[BZT_ZERO_WAIT_STATE_SELECT_BIT];
   assign zone_change = prev_valid_q && (zone_new != prev_zone_q);

   // reserved bits are dropped on write; only the reset value may hold a one there
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         zone0_static_timing_config_q <= BZT_ZONE_RESET;
         zone1_static_timing_config_q <= BZT_ZONE_RESET;
         io_zone_timing_config_q <= BZT_IO_ZONE_TIMING_CONFIG_RESET;
         general_bus_config_q <= BZT_BUSCFG_RESET;
         module_config_q <= BZT_MODCFG_RESET;
      end else if (clk_en_i && reg_wr_i) begin
         unique case (reg_addr_i)
            BZT_ZONE0_ADDR: begin
               zone0_static_timing_config_q <= reg_wdata_i & BZT_ZONE_WMASK;
            end
            BZT_ZONE1_ADDR: begin
               zone1_static_timing_config_q <= reg_wdata_i & BZT_ZONE_WMASK;
            end
            BZT_IO_ZONE_TIMING_CONFIG_ADDR: begin
               io_zone_timing_config_q <= reg_wdata_i & BZT_ZONE_WMASK;
            end
            BZT_BUSCFG_ADDR: begin
               general_bus_config_q <= {15'h0000, reg_wdata_i[BZT_EWR_BIT]};
            end
            BZT_MODCFG_ADDR: begin
               module_config_q <= {15'h0000, reg_wdata_i[BZT_ZERO_WAIT_STATE_SELECT_BIT]};
            end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      unique case (reg_addr_i)
         BZT_ZONE0_ADDR: rdata_d = zone0_static_timing_config_q;
         BZT_ZONE1_ADDR: rdata_d = zone1_static_timing_config_q;
         BZT_IO_ZONE_TIMING_CONFIG_ADDR: rdata_d = io_zone_timing_config_q;
         BZT_BUSCFG_ADDR: rdata_d = general_bus_config_q;
         BZT_MODCFG_ADDR: rdata_d = module_config_q;
         BZT_STATUS_ADDR: rdata_d = {10'h000, state_q};
         default: rdata_d = 16'h0000;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 16'h0000;
      end else if (clk_en_i) begin
         reg_rdata_o <= reg_rd_i ? rdata_d : 16'h0000;
      end
   end

   // per-cycle timing from zone and registers
   always_comb begin
      cfg_sel = zone1_static_timing_config_q;
      wait_d = 4'h0;
      hold_d = 2'h0;
      pre_d = 1'b0;
      post_d = 1'b0;
      wide_d = 1'b1;
      unique case (zone_new)
         BZT_Z_FLASH: begin
            cfg_sel = zone0_static_timing_config_q;
            if (fast_read) begin
               wait_d = cyc_write_i ? 4'h1 : 4'h0;
            end else begin
               wait_d = {1'b0, cfg_sel[BZT_WAIT_LSB +: 3]} + 4'h1;
               if (cyc_write_i && early_write) begin
                  wait_d = wait_d + 4'h1;
               end
               hold_d = cfg_sel[BZT_HOLD_LSB +: 2];
            end
         end
         BZT_Z_BOOT: begin
            if (!fast_read) begin
               wait_d = {1'b0, cfg_sel[BZT_WAIT_LSB +: 3]} + 4'h1;
               hold_d = cfg_sel[BZT_HOLD_LSB +: 2];
            end
         end
         BZT_Z_RAM: begin
            wait_d = 4'h0;
         end
         BZT_Z_EE: begin
            wait_d = zero_ws ? 4'h0 : 4'h1;
         end
         BZT_Z_PER: begin
            // the forced idle counts as the first of the two cycles
            pre_d = 1'b1;
         end
         BZT_Z_PORT: begin
            cfg_sel = io_zone_timing_config_q;
            wait_d = BZT_PORT_BASE_WAIT + {1'b0, cfg_sel[BZT_WAIT_LSB +: 3]};
            if (cyc_write_i && early_write) begin
               wait_d = wait_d + 4'h1;
            end
            hold_d = cfg_sel[BZT_HOLD_LSB +: 2];
         end
         BZT_Z_NONE: begin
            wait_d = 4'h0;
         end
      endcase
      wide_d = cfg_sel[BZT_BW_BIT];
      if (zone_new == BZT_Z_FLASH || zone_new == BZT_Z_BOOT) begin
         pre_d = cfg_sel[BZT_PRELIMINARY_IDLE_ENABLE_BIT] && zone_change;
         post_d = cfg_sel[BZT_POST_IDLE_ENABLE_BIT];
      end else if (zone_new == BZT_Z_PER) begin
         pre_d = 1'b1;
         post_d = 1'b0;
      end
   end

   // cycle sequencer
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         state_q <= ST_IDLE;
         wait_q <= 4'h0;
         hold_q <= 2'h0;
         post_q <= 1'b0;
         cur_zone_q <= BZT_Z_NONE;
         mem_wide_o <= 1'b1;
      end else if (clk_en_i) begin
         unique case (state_q)
            ST_IDLE: begin
               if (cyc_req_i) begin
                  wait_q <= wait_d;
                  hold_q <= hold_d;
                  post_q <= post_d;
                  cur_zone_q <= zone_new;
                  mem_wide_o <= wide_d;
                  if (post_pending_q && zone_change) begin
                     state_q <= ST_POST;
                  end else if (pre_d) begin
                     state_q <= ST_PRE;
                  end else if (wait_d != 4'h0) begin
                     state_q <= ST_WAIT;
                  end else if (hold_d != 2'h0) begin
                     state_q <= ST_HOLD;
                  end else begin
                     state_q <= ST_DONE;
                  end
               end
            end
            // both idle kinds cost one cycle; status tells them apart
            ST_PRE, ST_POST: begin
               if (wait_q != 4'h0) begin
                  state_q <= ST_WAIT;
               end else if (hold_q != 2'h0) begin
                  state_q <= ST_HOLD;
               end else begin
                  state_q <= ST_DONE;
               end
            end
            ST_WAIT: begin
               wait_q <= wait_q - 4'h1;
               if (wait_q == 4'h1) begin
                  state_q <= (hold_q != 2'h0) ? ST_HOLD : ST_DONE;
               end
            end
            ST_HOLD: begin
               hold_q <= hold_q - 2'h1;
               if (hold_q == 2'h1) begin
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: begin
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // zone history for idle insertion
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         prev_zone_q <= BZT_Z_NONE;
         prev_valid_q <= 1'b0;
         post_pending_q <= 1'b0;
      end else if (clk_en_i && state_q == ST_DONE) begin
         prev_zone_q <= cur_zone_q;
         prev_valid_q <= 1'b1;
         post_pending_q <= post_q;
      end
   end

   // one cycle is the final data cycle; single-cycle accesses finish in it
   assign cyc_ready_o = (state_q == ST_DONE);
   assign cyc_busy_o = (state_q != ST_IDLE);
   assign mem_strobe_o = (state_q == ST_WAIT) || (state_q == ST_DONE);
   assign mem_zone_o = cur_zone_q;
endmodule

// ### bzt_timing_monitor.sv
`timescale 1ns/1ps
module bzt_timing_monitor
   import bzt_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire logic [16:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic cyc_req_i,
   input wire logic cyc_write_i,
   input wire logic [16:0] cyc_addr_i,
   input wire logic cyc_ready_o,
   input wire logic cyc_busy_o,
   input wire logic mem_strobe_o
);
   logic fre_q;
   logic fast_q;
   logic zws_q;
   logic pst0_q;
   logic pst1_q;
   logic calm;
   logic take, fl, ram, ee, per, prt;
   // shadows of the few control bits the timing depends on
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         fre_q <= 1'b0;
         fast_q <= 1'b0;
         zws_q <= 1'b0;
         pst0_q <= 1'b1;
         pst1_q <= 1'b1;
      end else if (reg_wr_i && clk_en_i) begin
         if (reg_addr_i == BZT_ZONE0_ADDR) begin
            fre_q <= reg_wdata_i[11];
            fast_q <= reg_wdata_i[11:9] == 3'h4;
            pst0_q <= reg_wdata_i[9];
         end
         if (reg_addr_i == BZT_ZONE1_ADDR) begin
            pst1_q <= reg_wdata_i[9];
         end
         if (reg_addr_i == BZT_MODCFG_ADDR) begin
            zws_q <= reg_wdata_i[0];
         end
      end
   end
   assign take = cyc_req_i && !cyc_busy_o && clk_en_i;
   // a pending post idle from the zone left behind lengthens the next access
   assign calm = !pst0_q && !pst1_q;
   assign fl = cyc_addr_i <= BZT_FLASH_LO_END
      || (cyc_addr_i >= BZT_FLASH_HI_BEG && cyc_addr_i <= BZT_FLASH_HI_END);
   assign ram = cyc_addr_i >= BZT_RAM_BEG && cyc_addr_i <= BZT_RAM_END;
   assign ee = cyc_addr_i >= BZT_EE_BEG && cyc_addr_i <= BZT_EE_END;
   assign prt = cyc_addr_i >= BZT_PORT_BEG && cyc_addr_i <= BZT_PORT_END;
   assign per = (cyc_addr_i >= BZT_PER_BEG && cyc_addr_i <= BZT_PER_END)
      || (cyc_addr_i >= BZT_PER2_BEG && cyc_addr_i <= 17'h0FFFF);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_rdata_idle_zero: assert property (
      $past(clk_en_i) && !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
      else $error("read data not zero outside read slot");
   a_ready_in_access: assert property (cyc_ready_o |-> cyc_busy_o && mem_strobe_o)
      else $error("ready outside access phase");
   a_idle_after_done: assert property (cyc_ready_o && clk_en_i |=> !cyc_ready_o && !cyc_busy_o)
      else $error("no idle cycle after ready");
   a_ram_single: assert property (take && ram && calm |=> cyc_ready_o)
      else $error("ram access not single cycle");
   a_flash_fast: assert property (
      take && fl && !cyc_write_i && fast_q && calm |=> cyc_ready_o)
      else $error("fast flash read not single cycle");
   a_flash_normal: assert property (take && fl && !cyc_write_i && !fre_q |=> !cyc_ready_o)
      else $error("normal flash read too short");
   a_periph_two: assert property (take && per |=> !cyc_ready_o ##1 cyc_ready_o)
      else $error("peripheral access not two cycles");
   a_ee_zero_wait: assert property (take && ee && zws_q && calm |=> cyc_ready_o)
      else $error("eeprom zero wait access not one cycle");
   a_ee_one_wait: assert property (
      take && ee && !zws_q && calm |=> !cyc_ready_o ##1 cyc_ready_o)
      else $error("eeprom access not two cycles");
   a_port_three: assert property (take && prt |=> !cyc_ready_o [*2])
      else $error("port access shorter than three cycles");
   c_ram: cover property (take && ram);
   c_port: cover property (take && prt);
   c_fast: cover property (take && fl && fast_q);
endmodule

bind bzt_timing bzt_timing_monitor u_bzt_timing_monitor (
   .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cyc_req_i(cyc_req_i),
   .cyc_write_i(cyc_write_i), .cyc_addr_i(cyc_addr_i), .cyc_ready_o(cyc_ready_o),
   .cyc_busy_o(cyc_busy_o), .mem_strobe_o(mem_strobe_o));

// ### bzt_cpu_model.sv
`timescale 1ns/1ps
module bzt_cpu_model (
   input wire logic clk_i,
   input wire logic cyc_ready_i,
   output logic cyc_req_o,
   output logic cyc_write_o,
   output logic [16:0] cyc_addr_o
);
   initial begin
      cyc_req_o = 1'b0;
      cyc_write_o = 1'b0;
      cyc_addr_o = 17'h00000;
   end
   // gap lets the core idle before issuing; n returns cycles from take to ready
   task automatic access(input logic [16:0] a, input logic w, input int gap, output int n);
      repeat (gap + 1) @(posedge clk_i);
      cyc_req_o <= 1'b1;
      cyc_write_o <= w;
      cyc_addr_o <= a;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (cyc_ready_i !== 1'b1 && n < 40);
      // released lines show the inverse so a stale address is never mistaken
      cyc_req_o <= 1'b0;
      cyc_write_o <= ~w;
      cyc_addr_o <= ~a;
      n = n - 1;
   endtask
endmodule

// ### bus_zone_wait_state_timing_tb_top.sv
`timescale 1ns/1ps
module bus_zone_wait_state_timing_tb_top;
   import bzt_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [16:0] ra = 17'h00000;
   logic [15:0] rwd = 16'h0000;
   logic rwr = 1'b0;
   logic rrd = 1'b0;
   logic [15:0] rdata;
   logic req, cwr, ready, busy;
   logic [16:0] caddr;
   logic ce = 1'b1;
   logic [2:0] zone;
   logic wide;
   int err_total = 0;
   int compares = 0;
   always #2 clk = ~clk;
   bzt_timing u_bzt_timing (.sys_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(ce),
      .reg_addr_i(ra), .reg_wdata_i(rwd), .reg_wr_i(rwr), .reg_rd_i(rrd),
      .reg_rdata_o(rdata), .cyc_req_i(req), .cyc_write_i(cwr), .cyc_addr_i(caddr),
      .cyc_ready_o(ready), .cyc_busy_o(busy), .mem_strobe_o(), .mem_zone_o(zone),
      .mem_wide_o(wide));
   bzt_cpu_model u_bzt_cpu_model (.clk_i(clk), .cyc_ready_i(ready), .cyc_req_o(req),
      .cyc_write_o(cwr), .cyc_addr_o(caddr));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [16:0] a, input logic [15:0] d);
      @(posedge clk);
      rwr <= 1'b1;
      ra <= a;
      rwd <= d;
      @(posedge clk);
      rwr <= 1'b0;
   endtask
   task automatic rreg(input logic [16:0] a, input logic [15:0] exp);
      @(posedge clk);
      rrd <= 1'b1;
      ra <= a;
      @(posedge clk);
      rrd <= 1'b0;
      @(posedge clk);
      check(rdata, exp);
   endtask
   task automatic acc(input logic [16:0] a, input logic w, input int g, input int exp);
      int n;
      u_bzt_cpu_model.access(a, w, g, n);
      check(n[15:0], exp[15:0]);
   endtask
   // back-to-back access first, then one after a three-cycle gap; both are checked
   task automatic cyc(input logic [16:0] a, input logic w, input int exp);
      acc(a, w, 0, exp);
      acc(a, w, 3, exp);
   endtask
   task automatic t_reset();
      rreg(BZT_ZONE0_ADDR, 16'h069F);
      rreg(BZT_ZONE1_ADDR, 16'h069F);
      rreg(BZT_IO_ZONE_TIMING_CONFIG_ADDR, 16'h069F);
      rreg(BZT_BUSCFG_ADDR, 16'h0000);
      rreg(BZT_STATUS_ADDR, 16'h0001);
      rreg(17'h0F910, 16'h0000);
      cyc(17'h00100, 1'b0, 10);
      check(16'(zone), 16'(BZT_Z_FLASH));
      check(16'(wide), 16'h0001);
      wreg(BZT_ZONE1_ADDR, 16'h0880);
      check(16'(busy), 16'h0000);
      rreg(BZT_ZONE1_ADDR, 16'h0880);
   endtask
   task automatic t_flash();
      for (int w = 0; w < 8; w++) begin
         wreg(BZT_ZONE0_ADDR, 16'h0080 | 16'((w % 4) << 4) | 16'(w));
         wreg(BZT_BUSCFG_ADDR, 16'h0000);
         cyc(17'h00100, 1'b0, 2 + w + w % 4);
         cyc(17'h1BFFE, 1'b1, 2 + w + w % 4);
         wreg(BZT_BUSCFG_ADDR, 16'h0001);
         cyc(17'h10000, 1'b1, 3 + w + w % 4);
      end
   endtask
   task automatic t_fast();
      wreg(BZT_BUSCFG_ADDR, 16'h0000);
      wreg(BZT_ZONE0_ADDR, 16'h08B7);
      rreg(BZT_ZONE0_ADDR, 16'h08B7);
      cyc(17'h00200, 1'b0, 1);
      cyc(17'h1BFFE, 1'b0, 1);
      cyc(17'h00200, 1'b1, 2);
   endtask
   task automatic t_fixed();
      wreg(BZT_ZONE0_ADDR, 16'h0497);
      cyc(17'h0C000, 1'b0, 1);
      cyc(17'h0CFFE, 1'b1, 1);
      check(16'(zone), 16'(BZT_Z_RAM));
      wreg(BZT_MODCFG_ADDR, 16'h0001);
      cyc(17'h0F000, 1'b0, 1);
      cyc(17'h0F27E, 1'b1, 1);
      check(16'(zone), 16'(BZT_Z_EE));
      wreg(BZT_MODCFG_ADDR, 16'h0000);
      cyc(17'h0F000, 1'b1, 2);
      cyc(17'h0F800, 1'b0, 2);
      cyc(17'h0FAFE, 1'b1, 2);
      cyc(17'h0FFFE, 1'b0, 2);
      check(16'(zone), 16'(BZT_Z_PER));
   endtask
   task automatic t_port();
      wreg(BZT_IO_ZONE_TIMING_CONFIG_ADDR, 16'h0093);
      wreg(BZT_BUSCFG_ADDR, 16'h0000);
      cyc(17'h0FB00, 1'b0, 7);
      cyc(17'h0FB16, 1'b1, 7);
      wreg(BZT_BUSCFG_ADDR, 16'h0001);
      cyc(17'h0FB16, 1'b1, 8);
      wreg(BZT_IO_ZONE_TIMING_CONFIG_ADDR, 16'h0080);
      cyc(17'h0FB00, 1'b0, 3);
      check(16'(zone), 16'(BZT_Z_PORT));
   endtask
   task automatic t_idle();
      wreg(BZT_ZONE0_ADDR, 16'h0080);
      wreg(BZT_ZONE1_ADDR, 16'h0080);
      acc(17'h00100, 1'b0, 0, 2);
      acc(17'h0E000, 1'b0, 0, 2);
      wreg(BZT_ZONE0_ADDR, 16'h0280);
      acc(17'h00100, 1'b0, 0, 2);
      acc(17'h0E000, 1'b0, 0, 3);
      wreg(BZT_ZONE0_ADDR, 16'h0080);
      wreg(BZT_ZONE1_ADDR, 16'h0480);
      acc(17'h00100, 1'b0, 0, 2);
      acc(17'h0E000, 1'b0, 0, 3);
      acc(17'h0E002, 1'b0, 0, 2);
      check(16'(zone), 16'(BZT_Z_BOOT));
   endtask
   // a write while the clock enable is low must leave the register alone
   task automatic t_freeze();
      @(posedge clk);
      ce <= 1'b0;
      wreg(BZT_ZONE1_ADDR, 16'h0080);
      ce <= 1'b1;
      rreg(BZT_ZONE1_ADDR, 16'h0480);
   endtask
   task automatic results();
      if (err_total == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_flash();
      t_fast();
      t_fixed();
      t_port();
      t_idle();
      t_freeze();
      results();
   end
   // a full run takes under a thousand cycles
   initial begin
      #100000;
      err_total++;
      results();
   end
endmodule
